// ### rtl/external_bus_wait_state_timing.sv
// Access timing sequencer for the zoned external memory interface
`timescale 1ns/10ps
module external_bus_wait_state_timing
    import zone_timing_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire zone_timing_config_s zone_timing_config [ZONE_COUNT],
    input wire logic access_start,
    input wire access_req_s access_req,
    input wire logic external_ready_in,
    output logic access_busy,
    output logic access_done,
    output logic [ZONE_COUNT-1:0] zone_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [15:0] hardware_wait_states
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LEAD = 4'h2,
        ST_ACTIVE = 4'h4,
        ST_TRAIL = 4'h8
    } phase_e;

    phase_e state_reg, state_next;
    logic [COUNT_W-1:0] count_reg, count_next;
    zone_timing_config_s cfg_reg, cfg_next;
    logic write_reg, write_next;
    logic [ZONE_W-1:0] zone_reg, zone_next;
    logic [ZONE_COUNT-1:0] select_next;
    logic read_next, wr_next, busy_next, done_next;
    logic [15:0] wait_next;
    zone_timing_config_s cfg_sel;
    logic [COUNT_W-1:0] lead_len, active_len, trail_len;
    logic [COUNT_W-1:0] rl, ra, rt, wl, wa, wt;
    logic ready_used;

    // The selected zone's configuration is latched at start, so later edits cannot skew it
    assign cfg_sel = zone_timing_config[access_req.zone];

    phase_length #(.FIELD_W(LEAD_W)) u_rl (.field(cfg_reg.read_lead_cycles),
        .phase_doubling(cfg_reg.phase_doubling), .cycles(rl));
    phase_length #(.FIELD_W(ACTIVE_W)) u_ra (.field(cfg_reg.read_active_cycles),
        .phase_doubling(cfg_reg.phase_doubling), .cycles(ra));
    phase_length #(.FIELD_W(TRAIL_W)) u_rt (.field(cfg_reg.read_trail_cycles),
        .phase_doubling(cfg_reg.phase_doubling), .cycles(rt));
    phase_length #(.FIELD_W(LEAD_W)) u_wl (.field(cfg_reg.write_lead_cycles),
        .phase_doubling(cfg_reg.phase_doubling), .cycles(wl));
    phase_length #(.FIELD_W(ACTIVE_W)) u_wa (.field(cfg_reg.write_active_cycles),
        .phase_doubling(cfg_reg.phase_doubling), .cycles(wa));
    phase_length #(.FIELD_W(TRAIL_W)) u_wt (.field(cfg_reg.write_trail_cycles),
        .phase_doubling(cfg_reg.phase_doubling), .cycles(wt));

    // Phase lengths for the current direction; active carries its fixed extra cycle
    always_comb begin
        lead_len = write_reg ? wl : rl;
        active_len = (write_reg ? wa : ra) + COUNT_ONE;
        trail_len = write_reg ? wt : rt;
        ready_used = cfg_reg.ready_sampling_enable;
    end

    // Sequencer: zero-length trail is skipped, zero lead still spends one cycle, no legality check is made
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        cfg_next = cfg_reg;
        write_next = write_reg;
        zone_next = zone_reg;
        wait_next = hardware_wait_states;
        done_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (access_start) begin
                    cfg_next = cfg_sel;
                    write_next = access_req.write;
                    zone_next = access_req.zone;
                    wait_next = WAIT_ZERO;
                    count_next = COUNT_ONE;
                    state_next = ST_LEAD;
                end
            end
            ST_LEAD: begin
                // Counter starts at one each phase, so lead_len equals cycles
                if (count_reg >= lead_len) begin
                    state_next = ST_ACTIVE;
                    count_next = COUNT_ONE;
                end else begin
                    count_next = count_reg + COUNT_ONE;
                end
            end
            ST_ACTIVE: begin
                // Ready is only looked at once the programmed active time is spent
                if (count_reg < active_len) begin
                    count_next = count_reg + COUNT_ONE;
                end else if (ready_used && !external_ready_in) begin
                    wait_next = hardware_wait_states + 16'h0001;
                end else if (trail_len == '0) begin
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                end else begin
                    state_next = ST_TRAIL;
                    count_next = COUNT_ONE;
                end
            end
            ST_TRAIL: begin
                if (count_reg >= trail_len) begin
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                end else begin
                    count_next = count_reg + COUNT_ONE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Strobes follow the next phase so they change on the edge entering it
    always_comb begin
        select_next = SELECT_IDLE;
        read_next = 1'b1;
        wr_next = 1'b1;
        busy_next = (state_next != ST_IDLE);
        if (state_next != ST_IDLE) begin
            select_next[zone_next] = 1'b0;
        end
        if (state_next == ST_ACTIVE) begin
            read_next = write_next;
            wr_next = !write_next;
        end
    end

    // State registers, all on the timing clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
            cfg_reg <= '0;
            write_reg <= 1'b0;
            zone_reg <= '0;
            zone_select_n <= SELECT_IDLE;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            access_busy <= 1'b0;
            access_done <= 1'b0;
            hardware_wait_states <= WAIT_ZERO;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            cfg_reg <= cfg_next;
            write_reg <= write_next;
            zone_reg <= zone_next;
            zone_select_n <= select_next;
            read_strobe_n <= read_next;
            write_strobe_n <= wr_next;
            access_busy <= busy_next;
            access_done <= done_next;
            hardware_wait_states <= wait_next;
        end
    end

    // Checks on the sequencing
    strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(!read_strobe_n && !write_strobe_n)) else $error("both strobes low");
    strobe_in_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!read_strobe_n || !write_strobe_n) |-> (zone_select_n != SELECT_IDLE))
        else $error("strobe outside select");
    phase_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_TRAIL) |-> ($past(state_reg) inside {ST_ACTIVE, ST_TRAIL}))
        else $error("trail not after active");
    lead_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && access_start) |=> (state_reg == ST_LEAD))
        else $error("access not starting in lead");
    no_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE && !cfg_reg.ready_sampling_enable)
        |=> $stable(hardware_wait_states)) else $error("wait counted while ignored");
    wait_extend_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE && count_reg >= active_len && ready_used
        && !external_ready_in) |=> (state_reg == ST_ACTIVE && !$stable(hardware_wait_states)))
        else $error("not ready did not extend");
    done_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        access_done |-> (zone_select_n == SELECT_IDLE)) else $error("select held after end");
    busy_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        access_busy == (zone_select_n != SELECT_IDLE)) else $error("busy and select differ");

    // Phase counters never run past their programmed length; lead of zero still spends one
    lead_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_LEAD) |-> (count_reg <= lead_len || count_reg == COUNT_ONE))
        else $error("lead ran past its field");
    active_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE) |-> (count_reg <= active_len))
        else $error("active counter past its length");
    trail_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_TRAIL) |-> (count_reg <= trail_len && trail_len != '0))
        else $error("trail counter past its length");
    active_after_lead_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE) |-> ($past(state_reg) inside {ST_LEAD, ST_ACTIVE}))
        else $error("active not after lead");

    // Strobes mirror the registered phase, so a strobe edge marks a phase boundary
    strobe_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE) == (!read_strobe_n || !write_strobe_n))
        else $error("strobe not matching active phase");
    strobe_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        !read_strobe_n |-> !write_reg)
        else $error("read strobe on a write");
    select_zone_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg != ST_IDLE) |-> (zone_select_n == ~(ZONE_COUNT'(1) << zone_reg)))
        else $error("wrong zone selected");

    // A start seen mid access must not disturb the latched zone settings
    cfg_held_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg != ST_IDLE)
        |=> ($stable(cfg_reg) && $stable(zone_reg) && $stable(write_reg)))
        else $error("zone settings changed mid access");
    done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        access_done |=> !access_done)
        else $error("done held over one cycle");
    done_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        access_done |-> ($past(state_reg) inside {ST_ACTIVE, ST_TRAIL} && state_reg == ST_IDLE))
        else $error("done without a finished access");

    // Wait-state bookkeeping
    ready_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE && !ready_used && count_reg >= active_len)
        |=> (state_reg != ST_ACTIVE)) else $error("ignored ready stalled active");
    wait_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && access_start) |=> (hardware_wait_states == WAIT_ZERO))
        else $error("wait count not cleared at start");
endmodule // external_bus_wait_state_timing

// ### rtl/zone_timing_pkg.sv
// Package with constants and carrier types for the zone access timing sequencer
package zone_timing_pkg;
    localparam int ZONE_COUNT = 4;
    localparam int ZONE_W = 2;
    localparam int LEAD_W = 2;
    localparam int ACTIVE_W = 3;
    localparam int TRAIL_W = 2;
    localparam int COUNT_W = 5;
    localparam logic [ZONE_COUNT-1:0] SELECT_IDLE = 4'hF;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;
    localparam logic [15:0] WAIT_ZERO = 16'h0000;

    // Per-zone timing fields, packed as one configuration word
    typedef struct packed {
        logic [LEAD_W-1:0] read_lead_cycles;
        logic [ACTIVE_W-1:0] read_active_cycles;
        logic [TRAIL_W-1:0] read_trail_cycles;
        logic [LEAD_W-1:0] write_lead_cycles;
        logic [ACTIVE_W-1:0] write_active_cycles;
        logic [TRAIL_W-1:0] write_trail_cycles;
        logic phase_doubling;
        logic ready_sampling_enable;
        logic ready_async_select;
    } zone_timing_config_s;

    // Access request from the internal side
    typedef struct packed {
        logic [ZONE_W-1:0] zone;
        logic write;
    } access_req_s;
endpackage

// ### rtl/phase_length.sv
// Phase length calculator: field value scaled by the doubling setting
`timescale 1ns/10ps
module phase_length
    import zone_timing_pkg::*;
#(
    parameter int FIELD_W = 2
) (
    input wire logic [FIELD_W-1:0] field,
    input wire logic phase_doubling,
    output logic [COUNT_W-1:0] cycles
);
    // Doubling is a left shift, so the field is used as programmed or at twice that
    always_comb begin
        cycles = phase_doubling ? COUNT_W'({field, 1'b0}) : COUNT_W'(field);
    end
endmodule // phase_length

// ### tb/slow_peripheral_model.sv
// Behavioural external peripheral that stretches each strobe by holding ready low
`timescale 1ns/10ps
module slow_peripheral_model
    import zone_timing_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ZONE_COUNT-1:0] zone_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] hold_cycles,
    output logic external_ready_in
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic strobe_idle;

    // Count strobe cycles; saturate so a stuck strobe cannot wrap back out of ready
    assign strobe_idle = read_strobe_n & write_strobe_n;
    always_comb begin
        count_next = count_reg;
        if (strobe_idle || (&zone_select_n)) begin
            count_next = 8'h00;
        end else if (count_reg != 8'hFF) begin
            count_next = count_reg + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
        end else begin
            count_reg <= count_next;
        end
    end
    // Ready is pulled up outside strobes; low only for the commanded stretch
    assign external_ready_in = strobe_idle | (count_reg >= hold_cycles);
endmodule // slow_peripheral_model

// ### tb/external_bus_wait_state_timing_test.sv
// Testbench measuring lead, active and trail lengths of zone accesses
`timescale 1ns/10ps
module external_bus_wait_state_timing_test;
    import zone_timing_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic access_start = 1'b0;
    access_req_s access_req = '0;
    zone_timing_config_s cfg [ZONE_COUNT];
    logic access_busy, access_done, read_strobe_n, write_strobe_n, external_ready_in;
    logic [ZONE_COUNT-1:0] zone_select_n;
    logic [15:0] hardware_wait_states;
    logic [7:0] hold_cycles = 8'h00;
    int num_errors = 0;
    int comparisons = 0;

    always #50 clk = ~clk;

    external_bus_wait_state_timing dut_u (.clk(clk), .rst_n(rst_n),
        .zone_timing_config(cfg), .access_start(access_start), .access_req(access_req),
        .external_ready_in(external_ready_in), .access_busy(access_busy),
        .access_done(access_done), .zone_select_n(zone_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .hardware_wait_states(hardware_wait_states));
    slow_peripheral_model peer_u (.clk(clk), .rst_n(rst_n), .zone_select_n(zone_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .hold_cycles(hold_cycles), .external_ready_in(external_ready_in));

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One access; poke raises a second start during lead, which must be ignored
    task access(input int z, input logic wr, input logic [7:0] hold, input logic poke);
        int lead, act, trail, wrong, n, k, p, l, t, w;
        logic done;
        zone_timing_config_s c;
        c = cfg[z];
        k = c.phase_doubling ? 2 : 1;
        l = k * (wr ? c.write_lead_cycles : c.read_lead_cycles);
        p = k * (wr ? c.write_active_cycles : c.read_active_cycles) + 1;
        t = k * (wr ? c.write_trail_cycles : c.read_trail_cycles);
        if (l == 0) l = 1; // Lead of zero still takes one cycle
        // Model answers ready from strobe cycle hold + 1 on; ready is first looked at in cycle p
        w = (c.ready_sampling_enable && hold + 1 > p) ? hold + 1 - p : 0;
        {lead, act, trail, wrong, done} = '0;
        @(posedge clk);
        access_req <= '{zone: z[ZONE_W-1:0], write: wr};
        access_start <= 1'b1;
        hold_cycles <= hold;
        for (n = 0; n < 200 && !done; n++) begin
            @(posedge clk);
            access_start <= poke && n == 0;
            @(negedge clk);
            if ((wr ? read_strobe_n : write_strobe_n) !== 1'b1) wrong++;
            if (access_done === 1'b1) done = 1'b1;
            else if (zone_select_n === ~(4'h1 << z)) begin
                if ((wr ? write_strobe_n : read_strobe_n) === 1'b0) act++;
                else if (act == 0) lead++;
                else trail++;
            end else wrong++;
        end
        if (!done) begin
            num_errors++;
            results();
        end
        check("lead", lead, l);
        check("active", act, p + w);
        check("trail", trail, t);
        check("stray strobe or select", wrong, 0);
        check("wait states", hardware_wait_states, w);
        if (c.ready_sampling_enable)
            check("wait stretch", (hardware_wait_states != 0), hold >= p);
        @(negedge clk);
        check("idle after done", access_busy, 0);
        $display("access zone %0d write %0b ended", z, wr);
    endtask

    initial begin
        // Zones meet the programming limits except zone 2, kept illegal on purpose
        cfg[0] = '{2'h1, 3'h0, 2'h1, 2'h1, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0};
        cfg[1] = '{2'h2, 3'h3, 2'h2, 2'h1, 3'h2, 2'h3, 1'b1, 1'b1, 1'b0};
        cfg[2] = '{2'h0, 3'h0, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 1'b0, 1'b0};
        cfg[3] = '{2'h3, 3'h2, 2'h0, 2'h2, 3'h7, 2'h0, 1'b0, 1'b1, 1'b1};
        repeat (16) @(posedge clk);
        check("reset selects", {zone_select_n, read_strobe_n, write_strobe_n}, 6'h3F);
        check("reset busy", {access_busy, access_done, hardware_wait_states}, 0);
        rst_n <= 1'b1;
        access(0, 1'b0, 8'h05, 1'b0);
        access(0, 1'b1, 8'h05, 1'b1);
        access(1, 1'b0, 8'h0C, 1'b0);
        access(1, 1'b1, 8'h0A, 1'b1);
        access(2, 1'b0, 8'h04, 1'b0);
        access(2, 1'b1, 8'h00, 1'b0);
        access(3, 1'b0, 8'h00, 1'b0);
        access(3, 1'b1, 8'h0F, 1'b0);
        access(3, 1'b0, 8'h07, 1'b1);
        results();
    end
endmodule // external_bus_wait_state_timing_test
